// File: core/xfer_trap_regs.vh
`ifndef XFER_TRAP_REGS_VH
`define XFER_TRAP_REGS_VH

// ----------------------------------------------------------------
// apb register byte offsets
// ----------------------------------------------------------------
`define OFF_INSTR    8'h00
`define OFF_ACC      8'h04
`define OFF_INDEX    8'h08
`define OFF_STACK    8'h0C
`define OFF_PROG     8'h10
`define OFF_FLAGS    8'h14
`define OFF_STATUS   8'h18

// ----------------------------------------------------------------
// instruction word fields
// ----------------------------------------------------------------
`define INS_OP_LSB   0
`define INS_PRE_LSB  8
`define INS_OPND_LSB 16

// ----------------------------------------------------------------
// status bits
// ----------------------------------------------------------------
`define ST_BUSY      0
`define ST_HALT      1
`define ST_ERR       2

// ----------------------------------------------------------------
// flag register bit positions
// ----------------------------------------------------------------
`define FLG_V        7
`define FLG_H        4
`define FLG_I        3
`define FLG_N        2
`define FLG_Z        1
`define FLG_C        0
`define FLG_ONES     8'h60

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_FLAGS    8'h68
`define RST_STACK    16'h00FF
`define RST_PROG     16'h0000

// ----------------------------------------------------------------
// opcodes, prefix byte included in the upper half
// ----------------------------------------------------------------
`define OP_TRAP      16'h0083
`define OP_A2F       16'h0084
`define OP_F2A       16'h0085
`define OP_A2X       16'h0097
`define OP_X2A       16'h009F
`define OP_S2X       16'h0095
`define OP_X2S       16'h0094
`define OP_HALT      16'h008F
`define OP_TZ_DIR    16'h003D
`define OP_TZ_ACC    16'h004D
`define OP_TZ_XLO    16'h005D
`define OP_TZ_IDX1   16'h006D
`define OP_TZ_IDX    16'h007D
`define OP_TZ_STK1   16'h9E6D

// ----------------------------------------------------------------
// cycle counts
// ----------------------------------------------------------------
`define CYC_TRAP     4'h9
`define CYC_A2F      4'h2
`define CYC_ONE      4'h1
`define CYC_S2X      4'h2
`define CYC_X2S      4'h2
`define CYC_TZ_DIR   4'h3
`define CYC_TZ_IDX1  4'h3
`define CYC_TZ_IDX   4'h2
`define CYC_TZ_STK1  4'h4

`endif

// File: core/sign_zero_eval.v
`timescale 1ns/100ps
`include "xfer_trap_regs.vh"

// operand minus zero: v cleared, n and z from result, rest kept
module sign_zero_eval (
  input  wire [7:0] operand,   // value under test
  input  wire [7:0] flags_in,  // flags before the test
  output wire [7:0] flags_out  // flags after the test
);

  // ----------------------------------------------------------------
  // result and flag merge
  // ----------------------------------------------------------------
  wire [7:0] result;  // operand minus zero, never written back

  assign result = operand - 8'h00;

  assign flags_out = {1'b0, flags_in[6:3], result[7],
                      (result == 8'h00), flags_in[`FLG_C]};

endmodule // sign_zero_eval

// File: core/xfer_trap_core.v
// Function
// - trap bumps counter, pushes five bytes, decrementing
// - trap sets mask, loads vector, nine cycles
// - accumulator copied into flags, bits 6 and 5 forced set, two cycles
// - accumulator into index low, one cycle
// - flags into accumulator, one cycle, flags kept
// - test clears v, sets n z, no writeback
// - test opcodes and cycle counts per mode
// - stack plus one into index pair, two cycles
// - index low into accumulator, one cycle
// - index pair minus one into stack, two cycles
// - halt clears mask then stops processing
// - index pair is high byte then low
// - stack offset mode uses prefix and offset
// - indexed offset mode adds one offset byte
// - indexed plain mode addresses by pair only
`timescale 1ns/100ps
`include "xfer_trap_regs.vh"

module xfer_trap_core #(
  parameter [15:0] TRAP_VECTOR = 16'hFFF0
) (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output wire [15:0] mem_addr,
  output wire        mem_rd,
  output wire        mem_wr,
  output wire [7:0]  mem_wdata,
  input  wire [7:0]  mem_rdata,
  output wire        busy,
  output wire        halted
);

  // ----------------------------------------------------------------
  // architectural state
  // ----------------------------------------------------------------
  reg [7:0]  acc_r;           // accumulator
  reg [7:0]  idx_lo_r;        // index low byte
  reg [7:0]  idx_hi_r;        // index high byte
  reg [7:0]  flags_r;         // flag register
  reg [15:0] stack_ptr_r;     // stack pointer
  reg [15:0] prog_counter_r;  // program counter
  reg [23:0] instr_r;         // last accepted instruction word

  // ----------------------------------------------------------------
  // sequencing state
  // ----------------------------------------------------------------
  reg        busy_r;          // instruction in progress
  reg        halted_r;        // processing stopped
  reg        err_r;           // unknown opcode seen, sticky
  reg [3:0]  cyc_r;           // cycle within instruction
  reg [3:0]  last_r;          // final cycle index
  reg        is_trap_r;       // running the trap sequence
  reg        is_mtest_r;      // running a memory test

  // ----------------------------------------------------------------
  // bus outputs
  // ----------------------------------------------------------------
  reg [31:0] prdata_r;        // apb read data
  reg        pready_r;        // apb ready
  reg        pslverr_r;       // apb error
  reg [15:0] mem_addr_r;      // memory address
  reg        mem_rd_r;        // memory read strobe
  reg        mem_wr_r;        // memory write strobe
  reg [7:0]  mem_wdata_r;     // memory write data

  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign mem_addr  = mem_addr_r;
  assign mem_rd    = mem_rd_r;
  assign mem_wr    = mem_wr_r;
  assign mem_wdata = mem_wdata_r;
  assign busy      = busy_r;
  assign halted    = halted_r;

  // ----------------------------------------------------------------
  // apb phase decode
  // ----------------------------------------------------------------
  wire        acc_ph;         // access phase, answer not yet given
  wire        wr_ok;          // accepted write completes now
  wire [15:0] idx_pair;       // full index value
  wire [15:0] opcode;         // prefix and opcode from write data
  wire [7:0]  opnd;           // address or offset byte
  wire        start;          // instruction write accepted

  assign acc_ph   = psel & penable & ~pready_r;
  assign wr_ok    = psel & penable & pready_r & pwrite & ~pslverr_r;
  assign idx_pair = {idx_hi_r, idx_lo_r};
  assign opcode   = pwdata[`INS_PRE_LSB+7:`INS_OP_LSB];
  assign opnd     = pwdata[`INS_OPND_LSB+7:`INS_OPND_LSB];
  assign start    = wr_ok & (paddr == `OFF_INSTR);

  // ----------------------------------------------------------------
  // opcode decode: legality, length, operand address
  // ----------------------------------------------------------------
  reg        dec_ok;          // opcode known
  reg [3:0]  dec_cyc;         // cycle count
  reg        dec_rd;          // needs a memory operand
  reg [15:0] dec_addr;        // operand address

  always @* begin
    dec_ok   = 1'b1;
    dec_cyc  = `CYC_ONE;
    dec_rd   = 1'b0;
    dec_addr = 16'h0000;
    case (opcode)
      `OP_TRAP:   dec_cyc = `CYC_TRAP;
      `OP_A2F:    dec_cyc = `CYC_A2F;
      `OP_S2X:    dec_cyc = `CYC_S2X;
      `OP_X2S:    dec_cyc = `CYC_X2S;
      `OP_F2A,
      `OP_A2X,
      `OP_X2A,
      `OP_HALT,
      `OP_TZ_ACC,
      `OP_TZ_XLO: dec_cyc = `CYC_ONE;
      `OP_TZ_DIR: begin
        dec_cyc  = `CYC_TZ_DIR;
        dec_rd   = 1'b1;
        dec_addr = {8'h00, opnd};
      end
      `OP_TZ_IDX1: begin
        dec_cyc  = `CYC_TZ_IDX1;
        dec_rd   = 1'b1;
        dec_addr = idx_pair + {8'h00, opnd};
      end
      `OP_TZ_IDX: begin
        dec_cyc  = `CYC_TZ_IDX;
        dec_rd   = 1'b1;
        dec_addr = idx_pair;
      end
      `OP_TZ_STK1: begin
        dec_cyc  = `CYC_TZ_STK1;
        dec_rd   = 1'b1;
        dec_addr = stack_ptr_r + {8'h00, opnd};
      end
      default:    dec_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // test flag evaluation, register or memory operand
  // ----------------------------------------------------------------
  wire [7:0] test_src;        // operand under test
  wire [7:0] test_flags;      // flags after test

  assign test_src = busy_r ? mem_rdata :
                    ((opcode == `OP_TZ_ACC) ? acc_r : idx_lo_r);

  sign_zero_eval u_eval (
    .operand   (test_src),
    .flags_in  (flags_r),
    .flags_out (test_flags)
  );

  // ----------------------------------------------------------------
  // apb answer: ready one cycle into the access phase
  // ----------------------------------------------------------------
  reg [31:0] rd_val;          // read mux
  reg        bad;             // access refused

  always @* begin
    rd_val = 32'h0000_0000;
    bad    = 1'b0;
    case (paddr)
      `OFF_INSTR: begin
        rd_val = {8'h00, instr_r};
        bad    = pwrite & (busy_r | halted_r);
      end
      `OFF_ACC: begin
        rd_val = {24'h000000, acc_r};
        bad    = pwrite & busy_r;
      end
      `OFF_INDEX: begin
        rd_val = {16'h0000, idx_pair};
        bad    = pwrite & busy_r;
      end
      `OFF_STACK: begin
        rd_val = {16'h0000, stack_ptr_r};
        bad    = pwrite & busy_r;
      end
      `OFF_PROG: begin
        rd_val = {16'h0000, prog_counter_r};
        bad    = pwrite & busy_r;
      end
      `OFF_FLAGS: begin
        rd_val = {24'h000000, flags_r};
        bad    = pwrite & busy_r;
      end
      `OFF_STATUS: rd_val = {29'h0000000, err_r, halted_r, busy_r};
      default:     bad    = 1'b1;
    endcase
  end

  // answer registers
  always @(posedge clock) begin
    if (sys_rst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= acc_ph;
      pslverr_r <= acc_ph & bad;
      if (acc_ph) begin
        prdata_r <= (pwrite | bad) ? 32'h0000_0000 : rd_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // execution and register writes
  // ----------------------------------------------------------------
  wire [15:0] prog_next;      // counter past the trap opcode

  assign prog_next = prog_counter_r + 16'h0001;

  always @(posedge clock) begin
    if (sys_rst) begin
      acc_r          <= 8'h00;
      idx_lo_r       <= 8'h00;
      idx_hi_r       <= 8'h00;
      flags_r        <= `RST_FLAGS;
      stack_ptr_r    <= `RST_STACK;
      prog_counter_r <= `RST_PROG;
      instr_r        <= 24'h000000;
      busy_r         <= 1'b0;
      halted_r       <= 1'b0;
      err_r          <= 1'b0;
      cyc_r          <= 4'h0;
      last_r         <= 4'h0;
      is_trap_r      <= 1'b0;
      is_mtest_r     <= 1'b0;
      mem_addr_r     <= 16'h0000;
      mem_rd_r       <= 1'b0;
      mem_wr_r       <= 1'b0;
      mem_wdata_r    <= 8'h00;
    end else begin
      mem_rd_r <= 1'b0;
      mem_wr_r <= 1'b0;
      if (start) begin
        // new instruction from software
        instr_r <= pwdata[23:0];
        if (!dec_ok) begin
          err_r <= 1'b1;
        end else begin
          busy_r     <= 1'b1;
          cyc_r      <= 4'h0;
          last_r     <= dec_cyc - 4'h1;
          is_trap_r  <= (opcode == `OP_TRAP);
          is_mtest_r <= dec_rd;
          mem_rd_r   <= dec_rd;
          mem_addr_r <= dec_addr;
          case (opcode)
            `OP_TRAP: begin
              prog_counter_r <= prog_next;
              mem_wr_r       <= 1'b1;
              mem_addr_r     <= stack_ptr_r;
              mem_wdata_r    <= prog_next[7:0];
              stack_ptr_r    <= stack_ptr_r - 16'h0001;
            end
            `OP_A2F:   flags_r  <= acc_r | `FLG_ONES;
            `OP_A2X:   idx_lo_r <= acc_r;
            `OP_F2A:   acc_r    <= flags_r;
            `OP_X2A:   acc_r    <= idx_lo_r;
            `OP_S2X: begin
              idx_hi_r <= stack_ptr_r[15:8] + {7'h00, &stack_ptr_r[7:0]};
              idx_lo_r <= stack_ptr_r[7:0] + 8'h01;
            end
            `OP_X2S:   stack_ptr_r <= idx_pair - 16'h0001;
            `OP_HALT: begin
              flags_r[`FLG_I] <= 1'b0;
              halted_r        <= 1'b1;
            end
            `OP_TZ_ACC,
            `OP_TZ_XLO: flags_r <= test_flags;
            default:   flags_r <= flags_r;
          endcase
        end
      end else if (busy_r) begin
        // step through the running instruction
        cyc_r <= cyc_r + 4'h1;
        if (cyc_r == last_r) begin
          busy_r     <= 1'b0;
          is_trap_r  <= 1'b0;
          is_mtest_r <= 1'b0;
        end
        if (is_mtest_r && (cyc_r == 4'h1)) begin
          flags_r <= test_flags;
        end
        if (is_trap_r) begin
          case (cyc_r)
            4'h0, 4'h1, 4'h2, 4'h3: begin
              // remaining pushes, each followed by a decrement
              mem_wr_r    <= 1'b1;
              mem_addr_r  <= stack_ptr_r;
              stack_ptr_r <= stack_ptr_r - 16'h0001;
              case (cyc_r)
                4'h0:    mem_wdata_r <= prog_counter_r[15:8];
                4'h1:    mem_wdata_r <= idx_lo_r;
                4'h2:    mem_wdata_r <= acc_r;
                default: mem_wdata_r <= flags_r;
              endcase
            end
            4'h4: begin
              flags_r[`FLG_I] <= 1'b1;
              mem_rd_r        <= 1'b1;
              mem_addr_r      <= TRAP_VECTOR;
            end
            4'h5: begin
              mem_rd_r   <= 1'b1;
              mem_addr_r <= TRAP_VECTOR + 16'h0001;
            end
            4'h6:    prog_counter_r[15:8] <= mem_rdata;
            4'h7:    prog_counter_r[7:0]  <= mem_rdata;
            default: cyc_r <= cyc_r + 4'h1;
          endcase
        end
      end else if (wr_ok) begin
        // software access to state while idle
        case (paddr)
          `OFF_ACC:   acc_r <= pwdata[7:0];
          `OFF_INDEX: begin
            idx_hi_r <= pwdata[15:8];
            idx_lo_r <= pwdata[7:0];
          end
          `OFF_STACK: stack_ptr_r    <= pwdata[15:0];
          `OFF_PROG:  prog_counter_r <= pwdata[15:0];
          `OFF_FLAGS: flags_r        <= pwdata[7:0] | `FLG_ONES;
          `OFF_STATUS: begin
            if (pwdata[`ST_HALT]) begin
              halted_r <= 1'b0;
            end
            if (pwdata[`ST_ERR]) begin
              err_r <= 1'b0;
            end
          end
          default: err_r <= err_r;
        endcase
      end
    end
  end

endmodule // xfer_trap_core

// File: test/xfer_trap_core_assertions.sv
`timescale 1ns/100ps
`include "xfer_trap_regs.vh"

// watches the core's apb and memory pins against the instruction timing
module xfer_trap_core_assertions #(
  parameter [15:0] TRAP_VECTOR = 16'hFFF0  // vector location under test
) (
  input wire        clock,
  input wire        sys_rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [15:0] mem_addr,
  input wire        mem_rd,
  input wire        mem_wr,
  input wire [7:0]  mem_wdata,
  input wire [7:0]  mem_rdata,
  input wire        busy,
  input wire        halted
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  wire        go;    // accepted instruction write
  wire [15:0] op;    // opcode with prefix on the bus
  reg  [15:0] op_r;  // opcode of the instruction in flight
  assign op = pwdata[15:0];
  assign go = psel && penable && pready && pwrite && !pslverr && (paddr == `OFF_INSTR);

  // remember the last started opcode
  always @(posedge clock) begin
    if (sys_rst) begin
      op_r <= 16'h0000;
    end else if (go) begin
      op_r <= op;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  apb_answer_a: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("apb answer not in second access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  trap_span_a: assert property (go && op == `OP_TRAP |=> busy[*8] ##1 busy ##1 !busy)
    else $error("trap busy span wrong");
  trap_push_a: assert property (go && op == `OP_TRAP |=> mem_wr[*5] ##1 !mem_wr)
    else $error("trap push count wrong");
  trap_vector_a: assert property (go && op == `OP_TRAP |-> ##6
    (mem_rd && mem_addr == TRAP_VECTOR) ##1 (mem_rd && mem_addr == TRAP_VECTOR + 16'h0001))
    else $error("trap vector fetch wrong");
  push_down_a: assert property (mem_wr && $past(mem_wr)
    |-> mem_addr == $past(mem_addr) - 16'h0001)
    else $error("stack not decremented per push");
  test_no_write_a: assert property (mem_wr |-> op_r == `OP_TRAP)
    else $error("memory written outside trap");
  one_cycle_a: assert property (go &&
    (op == `OP_A2X || op == `OP_F2A || op == `OP_X2A) |=> busy ##1 !busy)
    else $error("single cycle move length wrong");
  two_cycle_a: assert property (go &&
    (op == `OP_A2F || op == `OP_S2X || op == `OP_X2S) |=> busy[*2] ##1 !busy)
    else $error("two cycle move length wrong");
  stack_test_a: assert property (go && op == `OP_TZ_STK1 |=> busy[*4] ##1 !busy)
    else $error("stack offset test length wrong");
  halt_a: assert property (go && op == `OP_HALT |=> ##[0:1] halted)
    else $error("halt not entered");
endmodule // xfer_trap_core_assertions

bind xfer_trap_core xfer_trap_core_assertions #(.TRAP_VECTOR(TRAP_VECTOR)) chk (.*);

// File: test/mem_model.sv
`timescale 1ns/100ps

// synchronous byte memory on the core bus
module mem_model (
  input  wire        clock,
  input  wire [15:0] mem_addr,
  input  wire        mem_rd,
  input  wire        mem_wr,
  input  wire [7:0]  mem_wdata,
  output reg  [7:0]  mem_rdata
);
  reg [7:0] m [0:65535];  // storage, preloaded by the bench
  initial mem_rdata = 8'h00;

  // write at the cycle end; read data valid the cycle after the strobe only
  always @(posedge clock) begin
    if (mem_wr) begin
      m[mem_addr] <= mem_wdata;
    end
    if (mem_rd) begin
      mem_rdata <= m[mem_addr];
    end else begin
      mem_rdata <= ~mem_rdata;  // stale data does not linger
    end
  end
endmodule // mem_model

// File: test/tb.sv
`timescale 1ns/100ps
`include "xfer_trap_regs.vh"

module tb;
  localparam [15:0] TV = 16'h0F00;  // trap vector for this run
  reg         clock, sys_rst, psel, penable, pwrite;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rdat;
  reg         rerr;
  wire [31:0] prdata;
  wire        pready, pslverr, mem_rd, mem_wr, busy, halted;
  wire [15:0] mem_addr;
  wire [7:0]  mem_wdata, mem_rdata;
  integer     n_fail, checks, i;
  reg  [31:0] tw [6] = '{32'h0040003D, 32'h0000004D, 32'h0000005D,
                         32'h0005006D, 32'h0000007D, 32'h00109E6D};
  reg  [7:0]  tv [6] = '{8'h7F, 8'h80, 8'h00, 8'hC3, 8'h01, 8'h00};
  reg  [7:0]  pu [5] = '{8'h35, 8'h12, 8'h77, 8'h55, 8'h60};

  xfer_trap_core #(.TRAP_VECTOR(TV)) dut (.clock(clock), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .busy(busy),
    .halted(halted));
  mem_model mem (.clock(clock), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  initial begin
    clock = 0;
    forever #4 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // prints the verdict and stops the run
  task end_of_test;
    if (n_fail == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task chk(input [31:0] g, input [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // one apb transfer, held until pready is seen at an edge; the watchdog ends a hang
  task xfer(input w, input [7:0] a, input [31:0] d);
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // read one register and compare
  task rchk(input [7:0] a, input [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rdat, e);
  endtask

  // waits for busy to fall; a stuck instruction ends the run as a failure
  task wait_idle;
    integer n;
    n = 0;
    @(posedge clock);
    while (busy !== 1'b0 && n < 40) begin
      @(posedge clock);
      n++;
    end
    if (busy !== 1'b0) begin
      n_fail++;
      end_of_test;
    end
  endtask

  task run(input [31:0] w);
    xfer(1, `OFF_INSTR, w);
    wait_idle;
  endtask

  // ----------------------------------------------------------------
  // watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    #100000;
    n_fail++;
    end_of_test;
  end

  // reset, then the scenarios in order
  initial begin
    n_fail = 0;
    checks = 0;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    mem.m[16'h0040] = 8'h7F;
    mem.m[16'h0305] = 8'hC3;
    mem.m[16'h0300] = 8'h01;
    mem.m[16'h0410] = 8'h00;
    mem.m[TV] = 8'hAB;
    mem.m[TV + 16'h0001] = 8'hCD;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    // reset values and an unmapped address
    rchk(`OFF_FLAGS, 32'h0000_0068);
    rchk(`OFF_STACK, 32'h0000_00FF);
    xfer(1'b0, 8'h1C, 32'h0000_0000);
    chk({31'h0, rerr}, 32'h0000_0001);
    chk(rdat, 32'h0000_0000);
    // register moves
    xfer(1'b1, `OFF_ACC, 32'h0000_0080);
    run({16'h0000, `OP_A2X});
    rchk(`OFF_INDEX, 32'h0000_0080);
    rchk(`OFF_FLAGS, 32'h0000_0068);
    xfer(1'b1, `OFF_INDEX, 32'h0000_1234);
    run({16'h0000, `OP_X2A});
    rchk(`OFF_ACC, 32'h0000_0034);
    run({16'h0000, `OP_F2A});
    rchk(`OFF_ACC, 32'h0000_0068);
    run({16'h0000, `OP_S2X});
    rchk(`OFF_INDEX, 32'h0000_0100);
    xfer(1'b1, `OFF_INDEX, 32'h0000_0200);
    run({16'h0000, `OP_X2S});
    rchk(`OFF_STACK, 32'h0000_01FF);
    xfer(1'b1, `OFF_ACC, 32'h0000_00D5);
    run({16'h0000, `OP_A2F});
    rchk(`OFF_FLAGS, 32'h0000_00F5);
    // sign and zero test in every addressing mode
    xfer(1'b1, `OFF_ACC, 32'h0000_0080);
    xfer(1'b1, `OFF_INDEX, 32'h0000_0300);
    xfer(1'b1, `OFF_STACK, 32'h0000_0400);
    for (i = 0; i < 6; i++) begin
      xfer(1'b1, `OFF_FLAGS, 32'h0000_0091);
      run(tw[i]);
      rchk(`OFF_FLAGS, {24'h000000, 5'b01110, tv[i][7], tv[i] == 8'h00, 1'b1});
    end
    rchk(`OFF_ACC, 32'h0000_0080);
    // trap, with a write refused while it runs
    xfer(1'b1, `OFF_PROG, 32'h0000_1234);
    xfer(1'b1, `OFF_ACC, 32'h0000_0055);
    xfer(1'b1, `OFF_INDEX, 32'h0000_0077);
    xfer(1'b1, `OFF_FLAGS, 32'h0000_0000);
    xfer(1'b1, `OFF_STACK, 32'h0000_0080);
    xfer(1'b1, `OFF_INSTR, {16'h0000, `OP_TRAP});
    xfer(1'b1, `OFF_ACC, 32'h0000_0000);
    chk({31'h0, rerr}, 32'h0000_0001);
    wait_idle;
    rchk(`OFF_PROG, 32'h0000_ABCD);
    rchk(`OFF_STACK, 32'h0000_007B);
    rchk(`OFF_FLAGS, 32'h0000_0068);
    rchk(`OFF_ACC, 32'h0000_0055);
    for (i = 0; i < 5; i++) begin
      chk(mem.m[16'h0080 - i], pu[i]);
    end
    // halt, a start refused while halted, wake, unknown opcode
    run({16'h0000, `OP_HALT});
    rchk(`OFF_STATUS, 32'h0000_0002);
    rchk(`OFF_FLAGS, 32'h0000_0060);
    xfer(1'b1, `OFF_INSTR, {16'h0000, `OP_A2X});
    chk({31'h0, rerr}, 32'h0000_0001);
    xfer(1'b1, `OFF_STATUS, 32'h0000_0002);
    rchk(`OFF_STATUS, 32'h0000_0000);
    run(32'h0000_0001);
    rchk(`OFF_STATUS, 32'h0000_0004);
    xfer(1'b1, `OFF_STATUS, 32'h0000_0004);
    rchk(`OFF_STATUS, 32'h0000_0000);
    end_of_test;
  end
endmodule // tb
